/* rtl/pda_pkg.sv */
package pda_pkg;

    // Widths
    localparam int          DW          = 8;
    localparam int          CFG_W       = 6;
    localparam int          BUS_W       = 16;
    localparam int          PIN_W       = 16;
    localparam int          CTL_W       = 4;

    // Register select codes
    localparam logic [1:0]  RS_PORT_A   = 2'h0;
    localparam logic [1:0]  RS_CTRL_A   = 2'h1;
    localparam logic [1:0]  RS_PORT_B   = 2'h2;
    localparam logic [1:0]  RS_CTRL_B   = 2'h3;

    // Control register fields
    localparam int          CR_FLAG1    = 7;
    localparam int          CR_FLAG2    = 6;
    localparam int          CR_C2_MODE  = 5;
    localparam int          CR_C2_EDGE  = 4;
    localparam int          CR_C2_EN    = 3;
    localparam int          CR_PORT_SEL = 2;
    localparam int          CR_C1_EDGE  = 1;
    localparam int          CR_C1_EN    = 0;

    // Reset values
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [5:0]  CFG_RESET   = 6'h00;

    // Synchronised processor bus sample
    typedef struct packed {
        logic       phi2;
        logic       reset_n;
        logic       rw;
        logic       sel_hi1;
        logic       sel_hi2;
        logic       sel_lo_n;
        logic [1:0] rs;
        logic [7:0] data;
    } pda_bus_t;

    // Registers of one side
    typedef struct packed {
        logic [5:0] ctrl;
        logic [7:0] dir;
        logic [7:0] outr;
    } pda_side_t;

    typedef enum logic [1:0] {
        PDA_IDLE,
        PDA_READ,
        PDA_WRITE
    } pda_state_t;

endpackage

/* rtl/pda_sync.sv */
`timescale 1ns/1ns
module pda_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         rst_in,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync;

    always_comb begin
        next_stage1 = async_in;
        next_sync   = stage1;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync;
        end
    end

endmodule

/* rtl/pda_ctl.sv */
`timescale 1ns/1ns
module pda_ctl
    import pda_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             clear_in,
    // Configuration and lines
    input  wire logic [CFG_W-1:0] ctrl_in,
    input  wire logic             ctl_first_in,
    input  wire logic             ctl_second_in,
    input  wire logic             flag_clr_in,
    // Flags
    output logic                  flag_first_out,
    output logic                  flag_second_out
);

    logic prev_first;
    logic prev_second;
    logic set_first;
    logic set_second;
    logic next_flag_first;
    logic next_flag_second;

    always_comb begin
        // Active edge: field bit 1 = rising, 0 = falling
        set_first  = ctrl_in[CR_C1_EDGE] ? (ctl_first_in & ~prev_first)
                                         : (~ctl_first_in & prev_first);
        set_second = ~ctrl_in[CR_C2_MODE] &
                     (ctrl_in[CR_C2_EDGE] ? (ctl_second_in & ~prev_second)
                                          : (~ctl_second_in & prev_second));
        // Set wins over a port-read clear
        next_flag_first  = set_first | (flag_first_out & ~flag_clr_in);
        next_flag_second = set_second | (flag_second_out & ~flag_clr_in);
        if (clear_in) begin
            next_flag_first  = 1'b0;
            next_flag_second = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_first      <= 1'b0;
            prev_second     <= 1'b0;
            flag_first_out  <= 1'b0;
            flag_second_out <= 1'b0;
        end else begin
            prev_first      <= ctl_first_in;
            prev_second     <= ctl_second_in;
            flag_first_out  <= next_flag_first;
            flag_second_out <= next_flag_second;
        end
    end

endmodule

/* rtl/pda_core.sv */
`timescale 1ns/1ns
module pda_core
    import pda_pkg::*;
(
    // Clock and reset
    input  wire logic          core_clk_in,
    input  wire logic          rst_in,
    // Processor bus
    input  wire logic          phi2_in,
    input  wire logic          reset_n_in,
    input  wire logic          rw_in,
    input  wire logic          select_high_first_in,
    input  wire logic          select_high_second_in,
    input  wire logic          select_low_n_in,
    input  wire logic          reg_select_lo_in,
    input  wire logic          reg_select_hi_in,
    input  wire logic [DW-1:0] data_in,
    output logic      [DW-1:0] data_out,
    output logic               data_oe_out,
    // Side A port
    input  wire logic [DW-1:0] side_a_pins_in,
    output logic      [DW-1:0] side_a_pins_out,
    output logic      [DW-1:0] side_a_pins_oe_out,
    input  wire logic          side_a_ctl_in,
    input  wire logic          side_a_ctl_io_in,
    output logic               side_a_ctl_io_out,
    output logic               side_a_ctl_io_oe_out,
    output logic               side_a_irq_n_out,
    output logic               side_a_irq_n_oe_out,
    // Side B port
    input  wire logic [DW-1:0] side_b_pins_in,
    output logic      [DW-1:0] side_b_pins_out,
    output logic      [DW-1:0] side_b_pins_oe_out,
    input  wire logic          side_b_ctl_in,
    input  wire logic          side_b_ctl_io_in,
    output logic               side_b_ctl_io_out,
    output logic               side_b_ctl_io_oe_out,
    output logic               side_b_irq_n_out,
    output logic               side_b_irq_n_oe_out
);

    pda_bus_t        bus_raw;
    pda_bus_t        bus;
    logic [PIN_W-1:0] pins_s;
    logic [CTL_W-1:0] ctl_s;
    logic [DW-1:0]   pa_s;
    logic [DW-1:0]   pb_s;

    pda_state_t      state;
    pda_state_t      next_state;
    logic            phi2_d;
    logic [DW-1:0]   hold_data;
    logic [DW-1:0]   next_hold_data;
    logic [1:0]      hold_rs;
    logic [1:0]      next_hold_rs;
    pda_side_t       side_a;
    pda_side_t       next_side_a;
    pda_side_t       side_b;
    pda_side_t       next_side_b;
    logic [DW-1:0]   next_data;
    logic            next_data_oe;
    logic            clr_a;
    logic            clr_b;

    logic            selected;
    logic            phi2_fall;
    logic            clear_all;
    logic            flag_a1;
    logic            flag_a2;
    logic            flag_b1;
    logic            flag_b2;
    logic [DW-1:0]   ctrl_a_full;
    logic [DW-1:0]   ctrl_b_full;
    logic [DW-1:0]   rd_value;

    // Every pin passes two flip-flops before use
    always_comb begin
        bus_raw.phi2     = phi2_in;
        bus_raw.reset_n  = reset_n_in;
        bus_raw.rw       = rw_in;
        bus_raw.sel_hi1  = select_high_first_in;
        bus_raw.sel_hi2  = select_high_second_in;
        bus_raw.sel_lo_n = select_low_n_in;
        bus_raw.rs       = {reg_select_hi_in, reg_select_lo_in};
        bus_raw.data     = data_in;
    end

    pda_sync #(.W(BUS_W)) u_sync_bus (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .async_in    (bus_raw),
        .sync_out    (bus)
    );

    pda_sync #(.W(PIN_W)) u_sync_pins (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .async_in    ({side_b_pins_in, side_a_pins_in}),
        .sync_out    (pins_s)
    );

    pda_sync #(.W(CTL_W)) u_sync_ctl (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .async_in    ({side_b_ctl_io_in, side_b_ctl_in, side_a_ctl_io_in, side_a_ctl_in}),
        .sync_out    (ctl_s)
    );

    assign pa_s = pins_s[DW-1:0];
    assign pb_s = pins_s[PIN_W-1:DW];

    // Status logic of each side
    pda_ctl u_ctl_a (
        .core_clk_in     (core_clk_in),
        .rst_in          (rst_in),
        .clear_in        (clear_all),
        .ctrl_in         (side_a.ctrl),
        .ctl_first_in    (ctl_s[0]),
        .ctl_second_in   (ctl_s[1]),
        .flag_clr_in     (clr_a),
        .flag_first_out  (flag_a1),
        .flag_second_out (flag_a2)
    );

    pda_ctl u_ctl_b (
        .core_clk_in     (core_clk_in),
        .rst_in          (rst_in),
        .clear_in        (clear_all),
        .ctrl_in         (side_b.ctrl),
        .ctl_first_in    (ctl_s[2]),
        .ctl_second_in   (ctl_s[3]),
        .flag_clr_in     (clr_b),
        .flag_first_out  (flag_b1),
        .flag_second_out (flag_b2)
    );

    // Access decode and read mux
    always_comb begin
        selected    = bus.sel_hi1 & bus.sel_hi2 & ~bus.sel_lo_n;
        phi2_fall   = phi2_d & ~bus.phi2;
        clear_all   = ~bus.reset_n;
        ctrl_a_full = {flag_a1, flag_a2, side_a.ctrl};
        ctrl_b_full = {flag_b1, flag_b2, side_b.ctrl};
        case (bus.rs)
            RS_PORT_A: begin
                if (side_a.ctrl[CR_PORT_SEL]) begin
                    rd_value = pa_s;
                end else begin
                    rd_value = side_a.dir;
                end
            end
            RS_CTRL_A: rd_value = ctrl_a_full;
            RS_PORT_B: begin
                if (side_b.ctrl[CR_PORT_SEL]) begin
                    rd_value = (side_b.outr & side_b.dir) | (pb_s & ~side_b.dir);
                end else begin
                    rd_value = side_b.dir;
                end
            end
            RS_CTRL_B: rd_value = ctrl_b_full;
            default:   rd_value = REG_RESET;
        endcase
    end

    // Access sequencer
    always_comb begin
        next_state     = state;
        next_hold_data = hold_data;
        next_hold_rs   = hold_rs;
        next_side_a    = side_a;
        next_side_b    = side_b;
        next_data      = data_out;
        next_data_oe   = 1'b0;
        clr_a          = 1'b0;
        clr_b          = 1'b0;
        case (state)
            PDA_IDLE: begin
                if (bus.phi2 && selected) begin
                    next_state   = bus.rw ? PDA_READ : PDA_WRITE;
                    next_hold_rs = bus.rs;
                end
            end
            PDA_READ: begin
                if (bus.phi2) begin
                    next_data    = rd_value;
                    next_data_oe = selected & bus.rw;
                end else begin
                    next_state = PDA_IDLE;
                    clr_a = (hold_rs == RS_PORT_A) & side_a.ctrl[CR_PORT_SEL];
                    clr_b = (hold_rs == RS_PORT_B) & side_b.ctrl[CR_PORT_SEL];
                end
            end
            PDA_WRITE: begin
                if (bus.phi2) begin
                    next_hold_data = bus.data;
                    next_hold_rs   = bus.rs;
                end else if (phi2_fall) begin
                    next_state = PDA_IDLE;
                    case (hold_rs)
                        RS_PORT_A: begin
                            if (side_a.ctrl[CR_PORT_SEL]) begin
                                next_side_a.outr = hold_data;
                            end else begin
                                next_side_a.dir = hold_data;
                            end
                        end
                        RS_CTRL_A: next_side_a.ctrl = hold_data[CFG_W-1:0];
                        RS_PORT_B: begin
                            if (side_b.ctrl[CR_PORT_SEL]) begin
                                next_side_b.outr = hold_data;
                            end else begin
                                next_side_b.dir = hold_data;
                            end
                        end
                        RS_CTRL_B: next_side_b.ctrl = hold_data[CFG_W-1:0];
                        default: begin
                            next_side_a = side_a;
                        end
                    endcase
                end else begin
                    next_state = PDA_IDLE;
                end
            end
            default: next_state = PDA_IDLE;
        endcase
        if (clear_all) begin
            next_state     = PDA_IDLE;
            next_hold_data = REG_RESET;
            next_side_a    = '{ctrl: CFG_RESET, dir: REG_RESET, outr: REG_RESET};
            next_side_b    = '{ctrl: CFG_RESET, dir: REG_RESET, outr: REG_RESET};
            next_data_oe   = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state       <= PDA_IDLE;
            phi2_d      <= 1'b0;
            hold_data   <= REG_RESET;
            hold_rs     <= RS_PORT_A;
            side_a      <= '{ctrl: CFG_RESET, dir: REG_RESET, outr: REG_RESET};
            side_b      <= '{ctrl: CFG_RESET, dir: REG_RESET, outr: REG_RESET};
            data_out    <= REG_RESET;
            data_oe_out <= 1'b0;
        end else begin
            state       <= next_state;
            phi2_d      <= bus.phi2;
            hold_data   <= next_hold_data;
            hold_rs     <= next_hold_rs;
            side_a      <= next_side_a;
            side_b      <= next_side_b;
            data_out    <= next_data;
            data_oe_out <= next_data_oe;
        end
    end

    // Port drivers, registered from the register state
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            side_a_pins_out      <= REG_RESET;
            side_a_pins_oe_out   <= REG_RESET;
            side_b_pins_out      <= REG_RESET;
            side_b_pins_oe_out   <= REG_RESET;
            side_a_ctl_io_out    <= 1'b1;
            side_a_ctl_io_oe_out <= 1'b0;
            side_b_ctl_io_out    <= 1'b1;
            side_b_ctl_io_oe_out <= 1'b0;
            side_a_irq_n_out     <= 1'b0;
            side_a_irq_n_oe_out  <= 1'b0;
            side_b_irq_n_out     <= 1'b0;
            side_b_irq_n_oe_out  <= 1'b0;
        end else begin
            side_a_pins_out      <= side_a.outr;
            side_a_pins_oe_out   <= side_a.dir;
            side_b_pins_out      <= side_b.outr;
            side_b_pins_oe_out   <= side_b.dir;
            side_a_ctl_io_out    <= side_a.ctrl[CR_C2_EDGE] ? side_a.ctrl[CR_C2_EN] : 1'b1;
            side_a_ctl_io_oe_out <= side_a.ctrl[CR_C2_MODE];
            side_b_ctl_io_out    <= side_b.ctrl[CR_C2_EDGE] ? side_b.ctrl[CR_C2_EN] : 1'b1;
            side_b_ctl_io_oe_out <= side_b.ctrl[CR_C2_MODE];
            side_a_irq_n_out     <= 1'b0;
            side_a_irq_n_oe_out  <= (flag_a1 & side_a.ctrl[CR_C1_EN]) |
                                    (flag_a2 & side_a.ctrl[CR_C2_EN] & ~side_a.ctrl[CR_C2_MODE]);
            side_b_irq_n_out     <= 1'b0;
            side_b_irq_n_oe_out  <= (flag_b1 & side_b.ctrl[CR_C1_EN]) |
                                    (flag_b2 & side_b.ctrl[CR_C2_EN] & ~side_b.ctrl[CR_C2_MODE]);
        end
    end

endmodule

/* dv/pda_cpu_model.sv */
`timescale 1ns/1ns
module pda_cpu_model
    import pda_pkg::*;
(
    // Clock
    input  wire logic          core_clk_in,
    // Device answer
    input  wire logic [DW-1:0] rdata_in,
    input  wire logic          rdata_oe_in,
    // Bus drive
    output pda_bus_t           bus_out
);
    initial begin
        bus_out = {1'b0, 1'b1, 1'b1, 3'b011, 2'h0, 8'h00};
    end

    // One phase-two access, sel is {high first, high second, low}
    task automatic access(input logic rd, input logic [2:0] sel, input logic [1:0] rs,
                          input logic [DW-1:0] wd, output logic [DW-1:0] rdat);
        @(posedge core_clk_in);
        #1;
        bus_out.rw = rd;
        {bus_out.sel_hi1, bus_out.sel_hi2, bus_out.sel_lo_n} = sel;
        bus_out.rs = rs;
        if (!rd) begin
            bus_out.data = wd;
        end
        repeat (2) @(posedge core_clk_in);
        #1;
        bus_out.phi2 = 1'b1;
        repeat (8) @(posedge core_clk_in);
        #1;
        rdat = rdata_oe_in ? rdata_in : 8'hxx;
        bus_out.phi2 = 1'b0;
        repeat (6) @(posedge core_clk_in);
        #1;
        bus_out.rw = 1'b1;
        {bus_out.sel_hi1, bus_out.sel_hi2, bus_out.sel_lo_n} = 3'b011;
        bus_out.data = ~bus_out.data;
    endtask

    // Hold the device reset pin low for a while
    task automatic device_reset();
        @(posedge core_clk_in);
        #1;
        bus_out.reset_n = 1'b0;
        repeat (6) @(posedge core_clk_in);
        #1;
        bus_out.reset_n = 1'b1;
        repeat (4) @(posedge core_clk_in);
    endtask
endmodule

/* dv/pda_core_monitor.sv */
`timescale 1ns/1ns
module pda_core_monitor
    import pda_pkg::*;
(
    // Clock and reset
    input wire logic          core_clk_in,
    input wire logic          rst_in,
    // Processor bus
    input wire logic          phi2_in,
    input wire logic          reset_n_in,
    input wire logic          rw_in,
    input wire logic          select_high_first_in,
    input wire logic          select_high_second_in,
    input wire logic          select_low_n_in,
    input wire logic          data_oe_out,
    // Ports
    input wire logic [DW-1:0] side_a_pins_out,
    input wire logic [DW-1:0] side_a_pins_oe_out,
    input wire logic [DW-1:0] side_b_pins_out,
    input wire logic [DW-1:0] side_b_pins_oe_out,
    input wire logic          side_a_ctl_in,
    input wire logic          side_a_ctl_io_in,
    input wire logic          side_a_irq_n_oe_out,
    input wire logic          side_b_ctl_in,
    input wire logic          side_b_ctl_io_in,
    input wire logic          side_b_irq_n_oe_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    chk_bus_release: assert property ((!phi2_in)[*4] |-> !data_oe_out)
        else $error("data bus driven outside phase two");
    chk_deselect_quiet: assert property (select_low_n_in[*4] |-> !data_oe_out)
        else $error("data bus driven while deselected");
    chk_write_quiet: assert property ((!rw_in)[*5] |-> !data_oe_out)
        else $error("data bus driven during write");
    chk_read_cause: assert property ($rose(data_oe_out) |-> $past(phi2_in, 2)
        && $past(rw_in, 2) && $past(select_high_first_in, 2)
        && $past(select_high_second_in, 2) && !$past(select_low_n_in, 2))
        else $error("data bus driven without selected read");
    chk_write_after_fall: assert property ((phi2_in && reset_n_in)[*6] |->
        $stable({side_a_pins_out, side_a_pins_oe_out, side_b_pins_out, side_b_pins_oe_out}))
        else $error("register changed while phase two high");
    chk_read_no_change: assert property ((rw_in && reset_n_in)[*8] |->
        $stable({side_a_pins_out, side_a_pins_oe_out, side_b_pins_out, side_b_pins_oe_out}))
        else $error("register changed without write");
    chk_flag_a_cause: assert property
        ((rw_in && $stable({side_a_ctl_in, side_a_ctl_io_in}))[*8] |->
        !$rose(side_a_irq_n_oe_out)) else $error("side a request without edge");
    chk_flag_b_cause: assert property
        ((rw_in && $stable({side_b_ctl_in, side_b_ctl_io_in}))[*8] |->
        !$rose(side_b_irq_n_oe_out)) else $error("side b request without edge");
    chk_flag_clear: assert property ((!phi2_in && reset_n_in)[*8] |->
        !$fell(side_a_irq_n_oe_out) && !$fell(side_b_irq_n_oe_out))
        else $error("request dropped without access");

    cov_read: cover property ($rose(data_oe_out));
    cov_flag_a: cover property ($rose(side_a_irq_n_oe_out));
    cov_clear_b: cover property ($fell(side_b_irq_n_oe_out));
endmodule

bind pda_core pda_core_monitor i_pda_core_monitor (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .phi2_in(phi2_in),
    .reset_n_in(reset_n_in), .rw_in(rw_in), .select_low_n_in(select_low_n_in),
    .select_high_first_in(select_high_first_in), .data_oe_out(data_oe_out),
    .select_high_second_in(select_high_second_in),
    .side_a_pins_out(side_a_pins_out), .side_a_pins_oe_out(side_a_pins_oe_out),
    .side_b_pins_out(side_b_pins_out), .side_b_pins_oe_out(side_b_pins_oe_out),
    .side_a_ctl_in(side_a_ctl_in), .side_a_ctl_io_in(side_a_ctl_io_in),
    .side_b_ctl_in(side_b_ctl_in), .side_b_ctl_io_in(side_b_ctl_io_in),
    .side_a_irq_n_oe_out(side_a_irq_n_oe_out), .side_b_irq_n_oe_out(side_b_irq_n_oe_out)
);

/* dv/dual_port_peripheral_adapter_core_test.sv */
`timescale 1ns/1ns
module dual_port_peripheral_adapter_core_test
    import pda_pkg::*;
;
    logic          core_clk_in = 1'b0;
    logic          rst_in = 1'b1;
    pda_bus_t      bus;
    logic [DW-1:0] data_out, a_out, a_oe, b_out, b_oe, rdata, pins_a, pins_b;
    logic          data_oe, a_io_out, a_io_oe, b_io_out, b_io_oe, a_irq, b_irq;
    logic          a_irq_n, b_irq_n;
    logic [DW-1:0] a_en = 8'h00, a_ext = 8'h00, b_en = 8'hff, b_ext = 8'h00;
    logic          a_ctl = 1'b0, a_io = 1'b1, b_ctl = 1'b0, b_io = 1'b1;
    logic [2:0]    bad [3] = '{3'b010, 3'b100, 3'b111};
    int            n_fail = 0;
    int            comparisons = 0;

    always #10 core_clk_in = ~core_clk_in;

    // Side A pulls undriven lines up, side B inverts them
    assign pins_a = (a_en & a_ext) | (~a_en & (~a_oe | a_out));
    assign pins_b = (b_en & b_ext) | (~b_en & ((b_oe & b_out) | (~b_oe & ~b_out)));

    pda_core i_pda_core (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .phi2_in(bus.phi2),
        .reset_n_in(bus.reset_n), .rw_in(bus.rw), .select_high_first_in(bus.sel_hi1),
        .select_high_second_in(bus.sel_hi2), .select_low_n_in(bus.sel_lo_n),
        .reg_select_lo_in(bus.rs[0]), .reg_select_hi_in(bus.rs[1]),
        .data_in(data_oe ? data_out : bus.data), .data_out(data_out), .data_oe_out(data_oe),
        .side_a_pins_in(pins_a), .side_a_pins_out(a_out), .side_a_pins_oe_out(a_oe),
        .side_a_ctl_in(a_ctl), .side_a_ctl_io_in(a_io_oe ? a_io_out : a_io),
        .side_a_ctl_io_out(a_io_out), .side_a_ctl_io_oe_out(a_io_oe),
        .side_a_irq_n_out(a_irq_n), .side_a_irq_n_oe_out(a_irq),
        .side_b_pins_in(pins_b), .side_b_pins_out(b_out), .side_b_pins_oe_out(b_oe),
        .side_b_ctl_in(b_ctl), .side_b_ctl_io_in(b_io_oe ? b_io_out : b_io),
        .side_b_ctl_io_out(b_io_out), .side_b_ctl_io_oe_out(b_io_oe),
        .side_b_irq_n_out(b_irq_n), .side_b_irq_n_oe_out(b_irq)
    );

    pda_cpu_model i_pda_cpu_model (
        .core_clk_in(core_clk_in), .rdata_in(data_out), .rdata_oe_in(data_oe), .bus_out(bus)
    );

    task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] rs, input logic [DW-1:0] d,
                      input logic [2:0] sel = 3'b110);
        i_pda_cpu_model.access(1'b0, sel, rs, d, rdata);
    endtask

    task automatic rd(input logic [1:0] rs, input logic [DW-1:0] exp,
                      input logic [2:0] sel = 3'b110);
        i_pda_cpu_model.access(1'b1, sel, rs, 8'h00, rdata);
        check(rdata, exp);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(2'(i), 8'h00);
        end
        done("reset values");
        wr(RS_PORT_A, 8'h0f);
        wr(RS_PORT_B, 8'hf0);
        rd(RS_PORT_A, 8'h0f);
        rd(RS_PORT_B, 8'hf0);
        wr(RS_CTRL_A, 8'hc4);
        wr(RS_CTRL_B, 8'h04);
        rd(RS_CTRL_A, 8'h04);
        wr(RS_PORT_A, 8'ha5);
        wr(RS_PORT_B, 8'h5a);
        check(a_oe, 8'h0f);
        check(b_oe, 8'hf0);
        check(a_out, 8'ha5);
        check(b_out, 8'h5a);
        done("register writes");
        a_en = 8'hf1;
        a_ext = 8'h30;
        b_ext = 8'h0c;
        rd(RS_PORT_A, 8'h34);
        rd(RS_PORT_B, 8'h5c);
        done("port reads");
        wr(RS_CTRL_A, 8'h07);
        wr(RS_CTRL_B, 8'h0c);
        a_ctl = 1'b1;
        b_io = 1'b0;
        repeat (8) @(posedge core_clk_in);
        #1;
        check({7'h00, a_irq}, 8'h01);
        check({7'h00, b_irq}, 8'h01);
        check({6'h00, a_irq_n, b_irq_n}, 8'h00);
        rd(RS_CTRL_A, 8'h87);
        rd(RS_CTRL_B, 8'h4c);
        rd(RS_PORT_A, 8'h34);
        rd(RS_PORT_B, 8'h5c);
        rd(RS_CTRL_A, 8'h07);
        rd(RS_CTRL_B, 8'h0c);
        check({7'h00, a_irq}, 8'h00);
        check({7'h00, b_irq}, 8'h00);
        done("status flags");
        wr(RS_CTRL_B, 8'h34);
        check({6'h00, b_io_oe, b_io_out}, 8'h02);
        check({6'h00, a_io_oe, a_io_out}, 8'h01);
        rd(RS_CTRL_B, 8'h34);
        done("control line output");
        for (int k = 0; k < 3; k++) begin
            wr(RS_CTRL_A, 8'h3b, bad[k]);
            rd(RS_CTRL_A, 8'hxx, bad[k]);
        end
        rd(RS_CTRL_A, 8'h07);
        done("deselected access");
        i_pda_cpu_model.device_reset();
        rd(RS_CTRL_A, 8'h00);
        rd(RS_PORT_A, 8'h00);
        check(b_out | b_oe, 8'h00);
        done("device reset");
        end_of_test();
    end
endmodule
